// [core/spdh_panel.sv]
// Contract
// R1: Digit presses past the last position return entry to the blank start.
// R2: Select at the high prompt skips to the low prompt.
// R3: Digit at a prompt blanks display; decimal point and unit bar flash.
// R4: First select after composing flashes whole display, nothing stored yet.
// R5: Second select while flashing commits the composed setpoint.
// R6: Digit while confirmation flashes returns to digit entry.
// R7: Select in normal indication reviews high then low setpoint.
// R8: Whole review lasts about six seconds.
// R9: Processor-driven outputs are suspended during review, resume after.
// R10: Review ends by itself back in normal pressure indication.
// R11: Low hold requests a freeze; the running update finishes first.
// R12: Display and digital updates stop until the hold level changes.
// R13: Display and digital output freeze on the same value.
// R14: Hold acknowledge reflects the hold line state.
// R15: Analog output always tracks pressure regardless of hold.
// R16: Up increments and down decrements the current digit.
// R17: Digit after choosing a digit shifts the value left one position.
// R18: Buttons are synchronised, debounced and acted on once per press.
// R19: Hold input is synchronised; acknowledge follows the synchronised level.
module spdh_panel #(
  parameter int unsigned     DIGITS          = spdh_pkg::DIGITS,
  parameter longint unsigned REVIEW_CYCLES   = spdh_pkg::REVIEW_CYCLES,
  parameter longint unsigned DEBOUNCE_CYCLES = spdh_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  digit_button,
  input  wire logic                  up_button,
  input  wire logic                  down_button,
  input  wire logic                  setpoint_select_button,
  input  wire logic                  entry_start,
  input  wire logic                  hold_n,
  input  wire logic [DIGITS*4-1:0]   meas_value,
  input  wire logic                  meas_update,
  output logic [DIGITS*4-1:0]        disp_digits,
  output logic [DIGITS-1:0]          disp_blank,
  output spdh_pkg::spdh_prompt_type  disp_prompt,
  output logic                       disp_flash_all,
  output logic                       disp_dp_unit_flash,
  output logic [DIGITS*4-1:0]        dig_out_value,
  output logic                       dig_out_strobe,
  output logic [DIGITS*4-1:0]        analog_value,
  output logic [DIGITS*4-1:0]        high_setpoint,
  output logic [DIGITS*4-1:0]        low_setpoint,
  output logic                       outputs_suspended,
  output logic                       hold_ack
);

  localparam int unsigned     VW     = DIGITS * 4;
  localparam int unsigned     NW     = $clog2(DIGITS + 1);
  localparam longint unsigned HALF   = REVIEW_CYCLES / 64'd2;
  localparam longint unsigned HI_END = HALF - 64'd1;
  localparam longint unsigned LO_END = REVIEW_CYCLES - HALF - 64'd1;
  localparam int unsigned     TW     = $clog2(HALF + 1);

  // entry shifts by whole digits, so one position alone cannot be served
  if (DIGITS < 2 || DIGITS > 8) begin : g_bad_digits
    $error("spdh_panel: DIGITS must be 2 to 8");
  end
  if (REVIEW_CYCLES < 2) begin : g_bad_review
    $error("spdh_panel: REVIEW_CYCLES must be at least 2");
  end

  function automatic logic [3:0] bcd_step(input logic [3:0] d, input logic up);
    if (up) begin
      return (d >= spdh_pkg::BCD_NINE) ? spdh_pkg::BCD_ZERO : d + 4'h1;
    end
    return (d == spdh_pkg::BCD_ZERO) ? spdh_pkg::BCD_NINE : d - 4'h1;
  endfunction

  logic       digit_press;
  logic       up_press;
  logic       down_press;
  logic       select_press;
  logic       hold_level;
  logic [3:0] button_raw;
  logic [3:0] button_press;

  assign button_raw = {setpoint_select_button, down_button, up_button, digit_button};
  assign {select_press, down_press, up_press, digit_press} = button_press;

  for (genvar b = 0; b < 4; b++) begin : g_button
    spdh_debounce #(.STABLE_CYCLES(32'(DEBOUNCE_CYCLES)), .RESET_LEVEL(1'b0)) u_button (
      .clock  (clock),
      .reset  (reset),
      .raw_in (button_raw[b]),
      .level  (),
      .rise   (button_press[b]) // see R18
    );
  end

  // hold line: three-stage sync, no extra filtering
  spdh_debounce #(.STABLE_CYCLES(spdh_pkg::HOLD_STABLE_CYCLES), .RESET_LEVEL(1'b1)) u_hold (
    .clock  (clock),
    .reset  (reset),
    .raw_in (hold_n),
    .level  (hold_level), // see R19
    .rise   ()
  );

  spdh_pkg::spdh_state_type state_q;
  spdh_pkg::spdh_state_type state_d;
  logic [VW-1:0] entry_q;
  logic [VW-1:0] entry_d;
  logic [NW-1:0] count_q;
  logic [NW-1:0] count_d;
  logic          target_low_q;
  logic          target_low_d;
  logic [VW-1:0] high_q;
  logic [VW-1:0] high_d;
  logic [VW-1:0] low_q;
  logic [VW-1:0] low_d;
  logic [TW-1:0] timer_q;
  logic [TW-1:0] timer_d;

  always_comb begin
    state_d      = state_q;
    entry_d      = entry_q;
    count_d      = count_q;
    target_low_d = target_low_q;
    high_d       = high_q;
    low_d        = low_q;
    timer_d      = timer_q;
    unique case (state_q)
      spdh_pkg::ST_NORMAL: begin
        if (entry_start) begin
          state_d = spdh_pkg::ST_HIGH_PROMPT;
        end else if (select_press) begin
          state_d = spdh_pkg::ST_REVIEW_HIGH; // see R7
          timer_d = '0;
        end
      end
      spdh_pkg::ST_HIGH_PROMPT, spdh_pkg::ST_LOW_PROMPT: begin
        if (select_press && state_q == spdh_pkg::ST_HIGH_PROMPT) begin
          state_d = spdh_pkg::ST_LOW_PROMPT; // see R2
        end else if (select_press) begin
          state_d = spdh_pkg::ST_NORMAL;
        end else if (digit_press) begin
          state_d      = spdh_pkg::ST_ENTRY_BLANK; // see R3
          target_low_d = (state_q == spdh_pkg::ST_LOW_PROMPT);
          entry_d      = '0;
          count_d      = '0;
        end
      end
      spdh_pkg::ST_ENTRY_BLANK: begin
        if (digit_press) begin
          state_d = spdh_pkg::ST_ENTRY_DIGIT;
          count_d = NW'(1);
        end
      end
      spdh_pkg::ST_ENTRY_DIGIT: begin
        if (select_press) begin
          state_d = spdh_pkg::ST_CONFIRM; // see R4
        end else if (digit_press) begin
          if (count_q >= NW'(DIGITS)) begin
            state_d = spdh_pkg::ST_ENTRY_BLANK; // see R1
            entry_d = '0;
            count_d = '0;
          end else begin
            entry_d = {entry_q[VW-5:0], spdh_pkg::BCD_ZERO}; // see R17
            count_d = count_q + NW'(1);
          end
        end else if (up_press || down_press) begin
          entry_d[3:0] = bcd_step(entry_q[3:0], up_press); // see R16
        end
      end
      spdh_pkg::ST_CONFIRM: begin
        if (digit_press) begin
          state_d = spdh_pkg::ST_ENTRY_DIGIT; // see R6
        end else if (select_press) begin
          high_d  = target_low_q ? high_q : entry_q; // see R5
          low_d   = target_low_q ? entry_q : low_q; // see R5
          state_d = target_low_q ? spdh_pkg::ST_NORMAL : spdh_pkg::ST_LOW_PROMPT;
        end
      end
      spdh_pkg::ST_REVIEW_HIGH, spdh_pkg::ST_REVIEW_LOW: begin
        timer_d = timer_q + TW'(1);
        if (state_q == spdh_pkg::ST_REVIEW_HIGH && timer_q >= TW'(HI_END)) begin // see R8
          state_d = spdh_pkg::ST_REVIEW_LOW;
          timer_d = '0;
        end else if (state_q == spdh_pkg::ST_REVIEW_LOW && timer_q >= TW'(LO_END)) begin // see R8
          state_d = spdh_pkg::ST_NORMAL; // see R10
          timer_d = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q      <= spdh_pkg::ST_NORMAL;
      entry_q      <= '0;
      count_q      <= '0;
      target_low_q <= 1'b0;
      high_q       <= '0;
      low_q        <= '0;
      timer_q      <= '0;
    end else begin
      state_q      <= state_d;
      entry_q      <= entry_d;
      count_q      <= count_d;
      target_low_q <= target_low_d;
      high_q       <= high_d;
      low_q        <= low_d;
      timer_q      <= timer_d;
    end
  end

  logic          reviewing;
  logic [VW-1:0] pend_q;
  logic [VW-1:0] pend_d;
  logic          busy_q;
  logic          busy_d;
  logic          frozen_q;
  logic          frozen_d;
  logic [VW-1:0] shown_q;
  logic [VW-1:0] shown_d;
  logic          strobe_q;
  logic          strobe_d;
  logic [VW-1:0] analog_q;
  logic [VW-1:0] analog_d;

  assign reviewing = (state_q == spdh_pkg::ST_REVIEW_HIGH) || (state_q == spdh_pkg::ST_REVIEW_LOW);

  always_comb begin
    pend_d   = pend_q;
    busy_d   = 1'b0;
    shown_d  = shown_q;
    strobe_d = 1'b0;
    analog_d = meas_update ? meas_value : analog_q; // see R15
    // an update already taken finishes before the freeze lands
    frozen_d = !hold_level && (frozen_q || !busy_q); // see R11 R12
    if (busy_q) begin
      shown_d  = pend_q; // see R13
      strobe_d = 1'b1;
    end else if (meas_update && !frozen_q && hold_level && !reviewing) begin // see R9
      pend_d = meas_value;
      busy_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pend_q   <= '0;
      busy_q   <= 1'b0;
      frozen_q <= 1'b0;
      shown_q  <= '0;
      strobe_q <= 1'b0;
      analog_q <= '0;
    end else begin
      pend_q   <= pend_d;
      busy_q   <= busy_d;
      frozen_q <= frozen_d;
      shown_q  <= shown_d;
      strobe_q <= strobe_d;
      analog_q <= analog_d;
    end
  end

  logic                      show_low;
  logic [VW-1:0]             dig_q;
  logic [VW-1:0]             dig_d;
  logic [DIGITS-1:0]         blank_q;
  logic [DIGITS-1:0]         blank_d;
  spdh_pkg::spdh_prompt_type prompt_q;
  spdh_pkg::spdh_prompt_type prompt_d;
  logic                      flash_q;
  logic                      flash_d;
  logic                      dpflash_q;
  logic                      dpflash_d;

  assign show_low = (state_d == spdh_pkg::ST_LOW_PROMPT) || (state_d == spdh_pkg::ST_REVIEW_LOW);

  always_comb begin
    dig_d     = shown_d;
    blank_d   = '0;
    prompt_d  = spdh_pkg::PROMPT_NONE;
    flash_d   = 1'b0;
    dpflash_d = 1'b0;
    unique case (state_d)
      spdh_pkg::ST_NORMAL: dig_d = shown_d;
      spdh_pkg::ST_HIGH_PROMPT, spdh_pkg::ST_LOW_PROMPT: begin
        blank_d  = '1;
        prompt_d = show_low ? spdh_pkg::PROMPT_LOW : spdh_pkg::PROMPT_HIGH;
      end
      spdh_pkg::ST_ENTRY_BLANK: begin
        dig_d     = '0;
        blank_d   = '1;
        dpflash_d = 1'b1; // see R3
      end
      spdh_pkg::ST_ENTRY_DIGIT, spdh_pkg::ST_CONFIRM: begin
        dig_d = entry_d;
        for (int i = 0; i < DIGITS; i++) begin
          blank_d[i] = (i >= int'(count_d));
        end
        flash_d = (state_d == spdh_pkg::ST_CONFIRM); // see R4
      end
      spdh_pkg::ST_REVIEW_HIGH, spdh_pkg::ST_REVIEW_LOW: begin
        dig_d    = show_low ? low_d : high_d; // see R7
        prompt_d = show_low ? spdh_pkg::PROMPT_LOW : spdh_pkg::PROMPT_HIGH;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dig_q     <= '0;
      blank_q   <= '0;
      prompt_q  <= spdh_pkg::PROMPT_NONE;
      flash_q   <= 1'b0;
      dpflash_q <= 1'b0;
    end else begin
      dig_q     <= dig_d;
      blank_q   <= blank_d;
      prompt_q  <= prompt_d;
      flash_q   <= flash_d;
      dpflash_q <= dpflash_d;
    end
  end

  assign disp_digits        = dig_q;
  assign disp_blank         = blank_q;
  assign disp_prompt        = prompt_q;
  assign disp_flash_all     = flash_q;
  assign disp_dp_unit_flash = dpflash_q;
  assign dig_out_value      = shown_q;
  assign dig_out_strobe     = strobe_q;
  assign analog_value       = analog_q;
  assign high_setpoint      = high_q;
  assign low_setpoint       = low_q;
  assign outputs_suspended  = reviewing || frozen_q;
  assign hold_ack           = hold_level; // see R14

endmodule

// [core/spdh_pkg.sv]
package spdh_pkg;

  // display geometry
  localparam int unsigned DIGITS     = 5;
  localparam int unsigned DIGIT_W    = 4;

  // clock rate and derived timing
  localparam longint unsigned CLOCK_HZ        = 64'd200_000_000;
  localparam longint unsigned REVIEW_TIME_MS  = 64'd6000;
  localparam longint unsigned REVIEW_CYCLES   = (REVIEW_TIME_MS * CLOCK_HZ) / 64'd1000;
  localparam longint unsigned DEBOUNCE_TIME_US = 64'd10000;
  localparam longint unsigned DEBOUNCE_CYCLES =
    ((DEBOUNCE_TIME_US * CLOCK_HZ) + 64'd999_999) / 64'd1_000_000;
  localparam int unsigned     HOLD_STABLE_CYCLES = 1;

  // BCD digit limits
  localparam logic [3:0] BCD_ZERO = 4'h0;
  localparam logic [3:0] BCD_NINE = 4'h9;

  // prompt codes shown on the display
  typedef enum logic [1:0] {
    PROMPT_NONE = 2'b00,
    PROMPT_HIGH = 2'b01,
    PROMPT_LOW  = 2'b10
  } spdh_prompt_type;

  typedef enum logic [2:0] {
    ST_NORMAL      = 3'b000,
    ST_HIGH_PROMPT = 3'b001,
    ST_LOW_PROMPT  = 3'b010,
    ST_ENTRY_BLANK = 3'b011,
    ST_ENTRY_DIGIT = 3'b100,
    ST_CONFIRM     = 3'b101,
    ST_REVIEW_HIGH = 3'b110,
    ST_REVIEW_LOW  = 3'b111
  } spdh_state_type;

endpackage

// [core/spdh_debounce.sv]
module spdh_debounce #(
  parameter int unsigned STABLE_CYCLES = 2,
  parameter bit          RESET_LEVEL   = 1'b0
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic raw_in,
  output logic      level,
  output logic      rise
);

  localparam int unsigned CW = (STABLE_CYCLES < 2) ? 1 : $clog2(STABLE_CYCLES + 1);

  if (STABLE_CYCLES < 1) begin : g_bad_stable
    $error("spdh_debounce: STABLE_CYCLES must be at least 1");
  end

  logic [2:0]    sync_q;
  logic [2:0]    sync_d;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic          level_q;
  logic          level_d;
  logic          rise_q;
  logic          rise_d;

  always_comb begin
    sync_d  = {sync_q[1:0], raw_in};
    count_d = count_q;
    level_d = level_q;
    rise_d  = 1'b0;
    // a change counts only once the second and third stages agree
    if ((sync_q[1] == sync_q[2]) && (sync_q[2] != level_q)) begin // see R18
      if (count_q >= CW'(STABLE_CYCLES - 1)) begin
        count_d = '0;
        level_d = sync_q[2];
        rise_d  = sync_q[2];
      end else begin
        count_d = count_q + CW'(1);
      end
    end else begin
      count_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sync_q  <= {3{RESET_LEVEL}};
      count_q <= '0;
      level_q <= RESET_LEVEL;
      rise_q  <= 1'b0;
    end else begin
      sync_q  <= sync_d;
      count_q <= count_d;
      level_q <= level_d;
      rise_q  <= rise_d;
    end
  end

  assign level = level_q;
  assign rise  = rise_q;

endmodule

// [testbench/spdh_front_panel.sv]
module spdh_front_panel (
  input  wire logic clock,
  output logic      digit_button,
  output logic      up_button,
  output logic      down_button,
  output logic      setpoint_select_button,
  output logic      hold_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] btn_q;

  initial begin
    btn_q  = 4'h0;
    hold_n = 1'b1;
  end

  assign {setpoint_select_button, down_button, up_button, digit_button} = btn_q;

  // contacts chatter for single cycles before settling closed
  task automatic press(input int b);
    repeat (2) begin
      @(negedge clock) btn_q[b] = 1'b1;
      @(negedge clock) btn_q[b] = 1'b0;
    end
    @(negedge clock) btn_q[b] = 1'b1;
  endtask

  task automatic let_go(input int b);
    @(negedge clock) btn_q[b] = 1'b0;
  endtask

  // low asks for a freeze, high lets the panel run again
  task automatic hold(input bit lvl);
    hold_n = lvl;
  endtask
endmodule

// [testbench/spdh_panel_props.sv]
module spdh_panel_props #(
  parameter int unsigned     DIGITS        = spdh_pkg::DIGITS,
  parameter longint unsigned REVIEW_CYCLES = spdh_pkg::REVIEW_CYCLES
) (
  input wire logic                      clock,
  input wire logic                      reset,
  input wire logic                      hold_n,
  input wire logic                      hold_ack,
  input wire logic [DIGITS*4-1:0]       meas_value,
  input wire logic                      meas_update,
  input wire logic [DIGITS*4-1:0]       analog_value,
  input wire logic [DIGITS*4-1:0]       dig_out_value,
  input wire logic                      dig_out_strobe,
  input wire logic [DIGITS*4-1:0]       disp_digits,
  input wire logic [DIGITS-1:0]         disp_blank,
  input wire spdh_pkg::spdh_prompt_type disp_prompt,
  input wire logic                      disp_flash_all,
  input wire logic                      disp_dp_unit_flash,
  input wire logic [DIGITS*4-1:0]       high_setpoint,
  input wire logic [DIGITS*4-1:0]       low_setpoint,
  input wire logic                      outputs_suspended
);
  timeunit 1ns;
  timeprecision 1ps;

  // review halves are 10 cycles at the simulated length of 20
  localparam int RV_LO = 8;
  localparam int RV_HI = 12;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  a_ack_low_hold: assert property ((!hold_n) [*5] |-> !hold_ack)
    else $error("acknowledge high while hold requested");
  a_ack_high_run: assert property (hold_n [*5] |-> hold_ack)
    else $error("acknowledge low while hold released");
  a_analog_tracks: assert property (meas_update |=> analog_value == $past(meas_value))
    else $error("analog value missed a reading");
  a_strobe_value: assert property (dig_out_strobe |-> $past(meas_update, 2)
    && dig_out_value == $past(meas_value, 2))
    else $error("digital output strobe without matching reading");
  a_frozen_quiet: assert property (outputs_suspended [*3] |-> !dig_out_strobe)
    else $error("digital output updated while suspended");
  a_blank_prompt: assert property (disp_dp_unit_flash |-> disp_blank == '1
    && !disp_flash_all)
    else $error("blank entry start not fully blank");
  a_confirm_nostore: assert property ($rose(disp_flash_all) |->
    $stable(high_setpoint) && $stable(low_setpoint))
    else $error("setpoint stored on first select");
  a_commit_confirm: assert property ($changed(high_setpoint) || $changed(low_setpoint) |->
    disp_flash_all || $past(disp_flash_all))
    else $error("setpoint changed outside confirmation");
  a_review_span: assert property ($rose(disp_prompt == spdh_pkg::PROMPT_HIGH)
    && outputs_suspended && hold_ack |-> disp_digits == high_setpoint
    ##[RV_LO:RV_HI] (disp_prompt == spdh_pkg::PROMPT_LOW && disp_digits == low_setpoint)
    ##[RV_LO:RV_HI] (disp_prompt == spdh_pkg::PROMPT_NONE && !outputs_suspended))
    else $error("setpoint review sequence wrong");

  cover property ($rose(disp_flash_all));
  cover property ($changed(high_setpoint));
  cover property ($rose(disp_prompt == spdh_pkg::PROMPT_LOW) && outputs_suspended);
  cover property ($fell(hold_ack));
endmodule

bind spdh_panel spdh_panel_props #(.DIGITS(DIGITS), .REVIEW_CYCLES(REVIEW_CYCLES)) u_props (
  .clock(clock), .reset(reset), .hold_n(hold_n), .hold_ack(hold_ack),
  .meas_value(meas_value), .meas_update(meas_update), .analog_value(analog_value),
  .dig_out_value(dig_out_value), .dig_out_strobe(dig_out_strobe),
  .disp_digits(disp_digits), .disp_blank(disp_blank), .disp_prompt(disp_prompt),
  .disp_flash_all(disp_flash_all), .disp_dp_unit_flash(disp_dp_unit_flash),
  .high_setpoint(high_setpoint), .low_setpoint(low_setpoint),
  .outputs_suspended(outputs_suspended)
);

// [testbench/test_spdh_panel.sv]
module test_spdh_panel;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int D = 0;
  localparam int UP = 1;
  localparam int DN = 2;
  localparam int SEL = 3;

  logic        clock, reset, entry_start, meas_update, hold_n;
  logic        digit_button, up_button, down_button, setpoint_select_button;
  logic [19:0] meas_value, disp_digits, dig_out_value, analog_value;
  logic [19:0] high_setpoint, low_setpoint, v, v2;
  logic [4:0]  disp_blank;
  logic        disp_flash_all, disp_dp_unit_flash, dig_out_strobe;
  logic        outputs_suspended, hold_ack;
  int          err_total, checks_done, seed, n, n1, i;
  logic [19:0] hi_m, ent;
  spdh_pkg::spdh_prompt_type disp_prompt;

  spdh_panel #(.REVIEW_CYCLES(20), .DEBOUNCE_CYCLES(2)) uut (
    .clock(clock), .reset(reset), .digit_button(digit_button), .up_button(up_button),
    .down_button(down_button), .setpoint_select_button(setpoint_select_button),
    .entry_start(entry_start), .hold_n(hold_n), .meas_value(meas_value),
    .meas_update(meas_update), .disp_digits(disp_digits), .disp_blank(disp_blank),
    .disp_prompt(disp_prompt), .disp_flash_all(disp_flash_all),
    .disp_dp_unit_flash(disp_dp_unit_flash), .dig_out_value(dig_out_value),
    .dig_out_strobe(dig_out_strobe), .analog_value(analog_value),
    .high_setpoint(high_setpoint), .low_setpoint(low_setpoint),
    .outputs_suspended(outputs_suspended), .hold_ack(hold_ack));

  spdh_front_panel panel (
    .clock(clock), .digit_button(digit_button), .up_button(up_button),
    .down_button(down_button), .setpoint_select_button(setpoint_select_button),
    .hold_n(hold_n));

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask

  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tap(input int b);
    panel.press(b);
    cyc(8);
    panel.let_go(b);
    cyc(8);
  endtask

  task automatic upd(input logic [19:0] val);
    meas_value = val;
    meas_update = 1'b1;
    cyc(1);
    meas_update = 1'b0;
    cyc(3);
  endtask

  task automatic wait_prompt(input spdh_pkg::spdh_prompt_type p);
    n = 0;
    while (disp_prompt !== p && n < 100) begin
      cyc(1);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      end_of_test();
    end
  endtask

  function automatic logic [19:0] rnd_bcd();
    logic [19:0] r;
    r = 20'h0;
    for (int k = 0; k < 5; k++) r = {r[15:0], 4'(unsigned'($random(seed)) % 10)};
    return r;
  endfunction

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    seed = 70;
    err_total = 0;
    checks_done = 0;
    reset = 1'b1;
    entry_start = 1'b0;
    meas_update = 1'b0;
    meas_value = 20'h0;
    hi_m = 20'h0;
    repeat (8) @(posedge clock);
    @(negedge clock) reset = 1'b0;
    cyc(4);
    for (i = 0; i < 4; i++) begin
      v = rnd_bcd();
      upd(v);
      chk("digital out", dig_out_value, v);
      chk("display", disp_digits, v);
      chk("analog", analog_value, v);
    end
    v = rnd_bcd();
    meas_value = v;
    meas_update = 1'b1;
    panel.hold(1'b0);
    cyc(1);
    meas_update = 1'b0;
    cyc(6);
    chk("hold ack low", 20'(hold_ack), 20'h0);
    chk("update in flight", dig_out_value, v);
    v2 = rnd_bcd();
    upd(v2);
    chk("frozen digital", dig_out_value, v);
    chk("frozen display", disp_digits, v);
    chk("analog in hold", analog_value, v2);
    panel.hold(1'b1);
    cyc(6);
    chk("hold ack high", 20'(hold_ack), 20'h1);
    upd(v2);
    chk("thawed digital", dig_out_value, v2);
    entry_start = 1'b1;
    cyc(1);
    entry_start = 1'b0;
    cyc(3);
    chk("high prompt", 20'(disp_prompt), 20'(spdh_pkg::PROMPT_HIGH));
    tap(D);
    chk("dp flash", 20'(disp_dp_unit_flash), 20'h1);
    chk("blank", 20'(disp_blank), 20'h1f);
    tap(D);
    n1 = int'(unsigned'($random(seed)) % 10);
    repeat (n1) tap(UP);
    tap(DN);
    ent = 20'((n1 + 9) % 10);
    chk("digit step", disp_digits, ent);
    tap(D);
    ent = ent << 4;
    chk("shift", disp_digits, ent);
    tap(UP);
    ent = ent + 20'h1;
    chk("second digit", disp_digits, ent);
    tap(SEL);
    chk("confirm flash", 20'(disp_flash_all), 20'h1);
    chk("not stored", high_setpoint, 20'h0);
    tap(SEL);
    hi_m = ent;
    chk("high commit", high_setpoint, hi_m);
    chk("low prompt", 20'(disp_prompt), 20'(spdh_pkg::PROMPT_LOW));
    tap(D);
    repeat (6) tap(D);
    chk("wrap dp flash", 20'(disp_dp_unit_flash), 20'h1);
    chk("wrap blank", 20'(disp_blank), 20'h1f);
    tap(D);
    tap(UP);
    tap(SEL);
    tap(D);
    chk("escape flash", 20'(disp_flash_all), 20'h0);
    chk("escape entry", 20'(disp_dp_unit_flash), 20'h0);
    tap(SEL);
    tap(SEL);
    chk("back normal", 20'(disp_prompt), 20'(spdh_pkg::PROMPT_NONE));
    chk("low commit", low_setpoint, 20'h1);
    entry_start = 1'b1;
    cyc(1);
    entry_start = 1'b0;
    cyc(3);
    tap(SEL);
    chk("skip high", 20'(disp_prompt), 20'(spdh_pkg::PROMPT_LOW));
    tap(SEL);
    chk("skip kept", high_setpoint, hi_m);
    chk("skip low kept", low_setpoint, 20'h1);
    panel.press(SEL);
    wait_prompt(spdh_pkg::PROMPT_HIGH);
    chk("review high", disp_digits, hi_m);
    chk("suspended", 20'(outputs_suspended), 20'h1);
    wait_prompt(spdh_pkg::PROMPT_LOW);
    n1 = n;
    chk("review low", disp_digits, 20'h1);
    chk("high half", 20'(n1), 20'd10);
    upd(rnd_bcd());
    wait_prompt(spdh_pkg::PROMPT_NONE);
    chk("review span", 20'(n1 + 4 + n), 20'd20);
    chk("review drop", dig_out_value, v2);
    panel.let_go(SEL);
    cyc(12);
    chk("single review", 20'(outputs_suspended), 20'h0);
    v = rnd_bcd();
    upd(v);
    chk("resumed", dig_out_value, v);
    chk("normal view", disp_digits, v);
    end_of_test();
  end
endmodule
